// file: logic/dkp_consts.vh
// Constants for the drive keypad and display controller.
`ifndef DKP_CONSTS_VH
`define DKP_CONSTS_VH
// APB register byte offsets.
`define DKP_CTRL_OFF 12'h000
`define DKP_STAT_OFF 12'h004
`define DKP_FUNC_OFF 12'h008
`define DKP_ELOG_OFF 12'h00C
`define DKP_SPEED_OFF 12'h010
// Control register fields and reset value.
`define DKP_CTRL_REMOTE 0
`define DKP_CTRL_COAST 1
`define DKP_CTRL_REFDISP 2
`define DKP_CTRL_RESET 32'h0000_0002
// Display mode codes.
`define DKP_DM_RPM 2'h0
`define DKP_DM_LOAD 2'h1
`define DKP_DM_VOLTS 2'h2
`define DKP_DM_REF 2'h3
// Function list: 00 to 18 and then the error log entry.
`define DKP_FUNC_LAST 5'h12
`define DKP_FUNC_ERR 5'h13
`define DKP_LOG_DEPTH 3
// Timing at 25 MHz.
`define DKP_CLK_HZ 25000000
`define DKP_DEB_US 10000
`define DKP_DEB_CYC ((`DKP_CLK_HZ / 1000000) * `DKP_DEB_US)
`define DKP_HOLD_MS 1000
`define DKP_HOLD_CYC ((`DKP_CLK_HZ / 1000) * `DKP_HOLD_MS)
`define DKP_SLOW_MS 250
`define DKP_SLOW_CYC ((`DKP_CLK_HZ / 1000) * `DKP_SLOW_MS)
`define DKP_FAST_MS 50
`define DKP_FAST_CYC ((`DKP_CLK_HZ / 1000) * `DKP_FAST_MS)
`define DKP_TEST_BANNER_A_MS 500
`define DKP_TEST_BANNER_A_CYC ((`DKP_CLK_HZ / 1000) * `DKP_TEST_BANNER_A_MS)
`endif

// file: logic/dkp_keypad_ui.v
// Keypad and display state machine of the drive controller with an APB register port.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dkp_consts.vh"
// Contract
// - Start only without fault and under local control.
// - Start ramps to setpoint, shows last mode.
// - Stop halts drive or clears cleared faults.
// - Stop while stopped leaves program mode.
// - Normal stop ramps or coasts per setting.
// - Instantaneous trip always coasts to stop.
// - Mode key cycles RPM, load, volts running.
// - Mode enters program only when stopped.
// - Direction key toggles direction LED immediately.
// - Arrows change speed or program selection.
// - Holding arrow over a second repeats faster.
// - Power up shows banner then saved mode.
// - Three modes, four with reference; RPM default.
// - Reference mode shows zero to hundred percent.
// - Fourth mode lights all three mode LEDs.
// - Program list holds functions 00-18, then log.
// - Enter shows value; again stores, back to number.
// - Log keeps first three faults, program only.
// - Down on first function wraps to log.
// - Up in log steps to next code.
// - Stop in log clears faults whose cause left.
// - Remote control ignores start and direction keys.
// - Program LED lit exactly in program mode.
module dkp_keypad_ui #(
   parameter DEB_CYC = `DKP_DEB_CYC,
   parameter HOLD_CYC = `DKP_HOLD_CYC,
   parameter SLOW_CYC = `DKP_SLOW_CYC,
   parameter FAST_CYC = `DKP_FAST_CYC,
   parameter TEST_BANNER_A_CYC = `DKP_TEST_BANNER_A_CYC
) (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [5:0] key_raw,
   input wire instantaneous_trip,
   input wire [7:0] fault_code,
   input wire fault_present,
   input wire [7:0] ref_pct,
   input wire [1:0] saved_mode,
   output reg run_cmd,
   output reg coast_cmd,
   output reg dir_rev,
   output reg [7:0] speed_ref,
   output reg [2:0] mode_led,
   output reg run_led,
   output reg prog_led,
   output reg fwd_led,
   output reg rev_led,
   output reg remote_led,
   output reg test_banner_a,
   output reg [7:0] disp_value,
   output reg [4:0] disp_func,
   output reg disp_show_value,
   output reg [1:0] disp_mode
);
   //----------------------------------------------------------------
   // Key indices and controller states
   //----------------------------------------------------------------
   // Key indices: start, stop, mode, dir, up, down.
   localparam K_START = 0;
   localparam K_STOP = 1;
   localparam K_MODE = 2;
   localparam K_DIR = 3;
   localparam K_UP = 4;
   localparam K_DOWN = 5;
   // The test_banner_a-test state is the reset state, so the banner shows first.
   localparam ST_TEST_BANNER_A = 2'd0;
   localparam ST_IDLE = 2'd1;
   localparam ST_RUN = 2'd2;
   localparam ST_PROG = 2'd3;

   function [2:0] mode_leds;
      input [1:0] m;
      begin
         case (m)
            `DKP_DM_RPM: mode_leds = 3'b001;
            `DKP_DM_LOAD: mode_leds = 3'b010;
            `DKP_DM_VOLTS: mode_leds = 3'b100;
            default: mode_leds = 3'b111;
         endcase
      end
   endfunction

   //----------------------------------------------------------------
   // Key debounce and edge detection
   //----------------------------------------------------------------
   // A key level must differ from the stable level for DEB_CYC cycles in a row before it
   // is taken, so contact bounce never reaches the state machine.
   wire [5:0] key_stable;
   wire [5:0] key_press;
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_deb
         reg [23:0] cnt_reg;
         reg stable_reg;
         reg prev_reg;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cnt_reg <= 24'h00_0000;
               stable_reg <= 1'b0;
               prev_reg <= 1'b0;
            end else if (clk_en) begin
               prev_reg <= stable_reg;
               if (key_raw[g] == stable_reg) begin
                  cnt_reg <= 24'h00_0000;
               end else if (cnt_reg >= DEB_CYC - 1) begin
                  stable_reg <= key_raw[g];
                  cnt_reg <= 24'h00_0000;
               end else begin
                  cnt_reg <= cnt_reg + 24'h00_0001;
               end
            end
         end
         assign key_stable[g] = stable_reg;
         assign key_press[g] = stable_reg & ~prev_reg;
      end
   endgenerate

   //----------------------------------------------------------------
   // Arrow hold-to-repeat
   //----------------------------------------------------------------
   reg [25:0] hold_reg;
   reg [25:0] rep_reg;
   wire arrow_held = key_stable[K_UP] | key_stable[K_DOWN];
   // The step period shortens once the arrow has been held for HOLD_CYC cycles.
   wire [31:0] rep_lim = (hold_reg >= HOLD_CYC) ? FAST_CYC : SLOW_CYC;
   wire rep_tick = arrow_held && (hold_reg >= SLOW_CYC) && (rep_reg >= rep_lim - 1);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_reg <= 26'h000_0000;
         rep_reg <= 26'h000_0000;
      end else if (clk_en) begin
         if (!arrow_held) begin
            hold_reg <= 26'h000_0000;
            rep_reg <= 26'h000_0000;
         end else begin
            if (hold_reg < HOLD_CYC) begin
               hold_reg <= hold_reg + 26'h000_0001;
            end
            rep_reg <= rep_tick ? 26'h000_0000 : rep_reg + 26'h000_0001;
         end
      end
   end
   // Up wins when both arrows are held.
   wire up_ev = key_press[K_UP] | (rep_tick & key_stable[K_UP]);
   wire dn_ev = key_press[K_DOWN] | (rep_tick & key_stable[K_DOWN] & ~key_stable[K_UP]);

   //----------------------------------------------------------------
   // Registers and the APB register port
   //----------------------------------------------------------------
   reg [31:0] ctrl_reg;
   reg [7:0] func_val_reg [0:18];
   reg [7:0] log_reg [0:2];
   reg [1:0] log_cnt_reg;
   reg [1:0] log_idx_reg;
   reg fault_reg;
   reg [1:0] state_reg;
   reg [24:0] test_banner_a_reg;
   reg [4:0] func_sel_reg;
   reg edit_reg;
   reg [7:0] edit_val_reg;
   wire remote = ctrl_reg[`DKP_CTRL_REMOTE];
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   // Writes to an unmapped offset are dropped without an error response.
   wire valid_addr = (paddr == `DKP_CTRL_OFF) || (paddr == `DKP_STAT_OFF) ||
                     (paddr == `DKP_FUNC_OFF) || (paddr == `DKP_ELOG_OFF) ||
                     (paddr == `DKP_SPEED_OFF);
   wire apb_wr = psel && penable && pwrite && valid_addr;
   // Read data is latched in the setup phase, so it stands through the access phase.

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (clk_en && psel && !penable && !pwrite) begin
         case (paddr)
            `DKP_CTRL_OFF: prdata <= ctrl_reg;
            `DKP_STAT_OFF: prdata <= {20'h0_0000, log_cnt_reg, fault_reg, dir_rev,
                                      disp_mode, state_reg, coast_cmd, run_cmd, prog_led,
                                      test_banner_a};
            `DKP_FUNC_OFF: prdata <= {19'h0_0000, func_sel_reg, edit_val_reg};
            `DKP_ELOG_OFF: prdata <= {8'h00, log_reg[2], log_reg[1], log_reg[0]};
            `DKP_SPEED_OFF: prdata <= {24'h00_0000, speed_ref};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   //----------------------------------------------------------------
   // Main control state machine
   //----------------------------------------------------------------
   // The fourth mode exists only while reference display is enabled.
   wire [1:0] max_mode = ctrl_reg[`DKP_CTRL_REFDISP] ? `DKP_DM_REF : `DKP_DM_VOLTS;
   integer i;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `DKP_CTRL_RESET;
         state_reg <= ST_TEST_BANNER_A;
         test_banner_a_reg <= 25'h000_0000;
         run_cmd <= 1'b0;
         coast_cmd <= 1'b0;
         dir_rev <= 1'b0;
         speed_ref <= 8'h00;
         disp_mode <= `DKP_DM_RPM;
         func_sel_reg <= 5'h00;
         edit_reg <= 1'b0;
         edit_val_reg <= 8'h00;
         fault_reg <= 1'b0;
         log_cnt_reg <= 2'h0;
         log_idx_reg <= 2'h0;
         for (i = 0; i < 19; i = i + 1) begin
            func_val_reg[i] <= 8'h00;
         end
         for (i = 0; i < 3; i = i + 1) begin
            log_reg[i] <= 8'h00;
         end
      end else if (clk_en) begin
         if (apb_wr && paddr == `DKP_CTRL_OFF) ctrl_reg <= {29'h0000_0000, pwdata[2:0]};
         if (apb_wr && paddr == `DKP_SPEED_OFF) speed_ref <= pwdata[7:0];
         // Fault capture: a new fault wins over a clear in the same cycle.
         if (instantaneous_trip) begin
            fault_reg <= 1'b1;
            // Only the first faults are kept; later ones are dropped until a clear.
            if (log_cnt_reg < `DKP_LOG_DEPTH) begin
               log_reg[log_cnt_reg] <= fault_code;
               log_cnt_reg <= log_cnt_reg + 2'h1;
            end
         end
         case (state_reg)
            // Hold the banner while the test_banner_a test runs, then restore the saved mode.
            ST_TEST_BANNER_A: begin
               if (test_banner_a_reg >= TEST_BANNER_A_CYC - 1) begin
                  state_reg <= ST_IDLE;
                  disp_mode <= saved_mode;
               end else begin
                  test_banner_a_reg <= test_banner_a_reg + 25'h000_0001;
               end
            end
            ST_IDLE: begin
               if (key_press[K_START] && !fault_reg && !instantaneous_trip && !remote) begin
                  state_reg <= ST_RUN;
                  run_cmd <= 1'b1;
                  coast_cmd <= 1'b0;
               end else if (key_press[K_STOP]) begin
                  if (!fault_present && !instantaneous_trip) fault_reg <= 1'b0;
               end else if (key_press[K_MODE]) begin
                  state_reg <= ST_PROG;
                  func_sel_reg <= 5'h00;
                  edit_reg <= 1'b0;
               end
               // The direction request toggles even while stopped; its LED shows it one cycle later.
               if (key_press[K_DIR] && !remote) begin
                  dir_rev <= ~dir_rev;
               end
               // Speed stepping saturates at both ends instead of wrapping.
               if (!remote && up_ev && speed_ref != 8'hFF) begin
                  speed_ref <= speed_ref + 8'h01;
               end
               if (!remote && dn_ev && speed_ref != 8'h00) begin
                  speed_ref <= speed_ref - 8'h01;
               end
            end
            ST_RUN: begin
               if (instantaneous_trip) begin
                  state_reg <= ST_IDLE;
                  run_cmd <= 1'b0;
                  // A trip always coasts, whatever the coast select says.
                  coast_cmd <= 1'b1;
               end else if (key_press[K_STOP]) begin
                  state_reg <= ST_IDLE;
                  run_cmd <= 1'b0;
                  coast_cmd <= ctrl_reg[`DKP_CTRL_COAST];
               end else if (key_press[K_MODE]) begin
                  disp_mode <= (disp_mode >= max_mode) ? `DKP_DM_RPM : disp_mode + 2'h1;
               end
               if (key_press[K_DIR] && !remote) begin
                  dir_rev <= ~dir_rev;
               end
               if (!remote && up_ev && speed_ref != 8'hFF) begin
                  speed_ref <= speed_ref + 8'h01;
               end
               if (!remote && dn_ev && speed_ref != 8'h00) begin
                  speed_ref <= speed_ref - 8'h01;
               end
            end
            default: begin
               // In the log entry the stop key clears; elsewhere it leaves program mode.
               if (key_press[K_STOP]) begin
                  if (func_sel_reg == `DKP_FUNC_ERR) begin
                     if (!fault_present && !instantaneous_trip) begin
                        fault_reg <= 1'b0;
                        log_cnt_reg <= 2'h0;
                        log_idx_reg <= 2'h0;
                     end
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end else if (key_press[K_MODE] && func_sel_reg != `DKP_FUNC_ERR) begin
                  if (!edit_reg) begin
                     edit_reg <= 1'b1;
                     edit_val_reg <= func_val_reg[func_sel_reg];
                  end else begin
                     edit_reg <= 1'b0;
                     func_val_reg[func_sel_reg] <= edit_val_reg;
                  end
               end else if (edit_reg) begin
                  if (up_ev) edit_val_reg <= edit_val_reg + 8'h01;
                  else if (dn_ev) edit_val_reg <= edit_val_reg - 8'h01;
               end else if (func_sel_reg == `DKP_FUNC_ERR && up_ev) begin
                  log_idx_reg <= (log_idx_reg >= 2'h2) ? 2'h0 : log_idx_reg + 2'h1;
               end else if (up_ev) begin
                  func_sel_reg <= func_sel_reg + 5'h01;
               end else if (dn_ev) begin
                  func_sel_reg <= (func_sel_reg == 5'h00) ? `DKP_FUNC_ERR :
                                  func_sel_reg - 5'h01;
               end
            end
         endcase
      end
   end

   //----------------------------------------------------------------
   // Display and LED outputs
   //----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_led <= 3'b000;
         run_led <= 1'b0;
         prog_led <= 1'b0;
         fwd_led <= 1'b0;
         rev_led <= 1'b0;
         remote_led <= 1'b0;
         test_banner_a <= 1'b1;
         disp_value <= 8'h00;
         disp_func <= 5'h00;
         disp_show_value <= 1'b0;
      end else if (clk_en) begin
         // LEDs follow the state one cycle later; the banner blanks the mode LEDs.
         test_banner_a <= (state_reg == ST_TEST_BANNER_A);
         mode_led <= (state_reg == ST_TEST_BANNER_A) ? 3'b000 : mode_leds(disp_mode);
         run_led <= run_cmd;
         prog_led <= (state_reg == ST_PROG);
         fwd_led <= ~dir_rev;
         rev_led <= dir_rev;
         remote_led <= remote;
         disp_func <= func_sel_reg;
         disp_show_value <= (state_reg == ST_PROG) && (edit_reg || func_sel_reg == `DKP_FUNC_ERR);
         if (state_reg == ST_PROG) begin
            disp_value <= (func_sel_reg == `DKP_FUNC_ERR) ? log_reg[log_idx_reg] : edit_val_reg;
         end else if (disp_mode == `DKP_DM_REF) begin
            disp_value <= (ref_pct > 8'h64) ? 8'h64 : ref_pct;
         end else begin
            // A stopped drive shows zero in every measured mode.
            disp_value <= run_cmd ? speed_ref : 8'h00;
         end
      end
   end
endmodule // dkp_keypad_ui
`default_nettype wire

// file: tb/dkp_keypad_ui_props.sv
// Concurrent checks on the ports of the keypad controller.
`timescale 1ns/1ps
`default_nettype none
`include "dkp_consts.vh"
module dkp_keypad_ui_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic instantaneous_trip,
   input wire logic [1:0] saved_mode,
   input wire logic run_cmd,
   input wire logic coast_cmd,
   input wire logic dir_rev,
   input wire logic [2:0] mode_led,
   input wire logic run_led,
   input wire logic prog_led,
   input wire logic rev_led,
   input wire logic remote_led,
   input wire logic test_banner_a,
   input wire logic [4:0] disp_func,
   input wire logic [1:0] disp_mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------------------------------------------------------------
   // Power-up banner and restored display mode, then start, trip, LED, program and remote checks.
   // ------------------------------------------------------------
   sequence s_banner;
      test_banner_a [*8] ##[1:40] !test_banner_a;
   endsequence
   a_banner_then_mode: assert property ($rose(presetn) |-> s_banner ##1 (disp_mode == saved_mode))
      else $error("banner or restored mode wrong");
   a_start_local: assert property ($rose(run_cmd) |-> !remote_led)
      else $error("start under remote control");
   a_start_leds: assert property ($rose(run_cmd) |=> run_led && mode_led != 3'h0)
      else $error("start without run or mode led");
   a_trip_coast: assert property (instantaneous_trip && run_cmd |-> ##[1:3] (coast_cmd && !run_cmd))
      else $error("trip did not coast to stop");
   a_dir_led: assert property ($changed(dir_rev) |=> rev_led == dir_rev)
      else $error("direction led does not follow direction");
   a_ref_leds: assert property (!test_banner_a && disp_mode == `DKP_DM_REF && $past(disp_mode) == `DKP_DM_REF |-> mode_led == 3'h7)
      else $error("reference mode leds wrong");
   a_prog_stopped: assert property ($rose(prog_led) |-> !run_cmd)
      else $error("program mode entered while running");
   a_func_range: assert property (disp_func <= `DKP_FUNC_ERR)
      else $error("function selection out of list");
   a_remote_dir: assert property (remote_led && $past(remote_led) |-> $stable(dir_rev))
      else $error("direction changed under remote control");
endmodule // dkp_keypad_ui_props
bind dkp_keypad_ui dkp_keypad_ui_props u_props (.pclk, .presetn, .instantaneous_trip, .saved_mode,
   .run_cmd, .coast_cmd, .dir_rev, .mode_led, .run_led, .prog_led, .rev_led, .remote_led,
   .test_banner_a, .disp_func, .disp_mode);
`default_nettype wire

// file: tb/dkp_panel_model.sv
// Operator keypad model: presses one key with contact bounce, then holds it.
`timescale 1ns/1ps
`default_nettype none
module dkp_panel_model (
   input wire logic pclk,
   input wire logic go,
   input wire logic [2:0] key_idx,
   output var logic [5:0] key_raw,
   output var logic busy
);
   logic [3:0] cnt;
   initial begin
      key_raw = 6'h00;
      busy = 1'b0;
      cnt = 4'h0;
   end
   always @(posedge pclk) begin
      if (go && !busy) begin
         busy <= 1'b1;
         cnt <= 4'h0;
      end else if (busy) begin
         cnt <= cnt + 4'h1;
         // One bounce at the start, a clean hold, then release.
         key_raw <= (cnt == 4'h1 || cnt == 4'hC) ? 6'h00 : 6'h01 << key_idx;
         if (cnt == 4'hC) begin
            busy <= 1'b0;
         end
      end
   end
endmodule // dkp_panel_model
`default_nettype wire

// file: tb/drive_keypad_ui_controller_test.sv
// Test_banner_a-checking testbench of the keypad controller.
`timescale 1ns/1ps
`default_nettype none
`include "dkp_consts.vh"
module drive_keypad_ui_controller_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [5:0] key_raw;
   logic trip = 0, fault_present = 0, go = 0, clk_en = 1;
   logic [7:0] fault_code = 8'h00, ref_pct = 8'h37, speed_ref, disp_value;
   logic [2:0] key_idx = 3'h0, mode_led;
   logic [1:0] saved_mode = 2'h1, disp_mode;
   logic [4:0] disp_func;
   logic run_cmd, coast_cmd, dir_rev, run_led, prog_led, fwd_led, rev_led, remote_led, banner, show;
   logic busy;
   int n_mismatch = 0, total_checks = 0;
   // Row: key, run, reverse, display mode.
   logic [6:0] rows [6] = '{7'h09, 7'h3D, 7'h2E, 7'h2C, 7'h2D, 7'h15};
   dkp_keypad_ui #(.DEB_CYC(4), .HOLD_CYC(200), .SLOW_CYC(50), .FAST_CYC(10), .TEST_BANNER_A_CYC(20)) DUT (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .key_raw(key_raw), .instantaneous_trip(trip), .fault_code(fault_code),
      .fault_present(fault_present), .ref_pct(ref_pct), .saved_mode(saved_mode),
      .run_cmd(run_cmd), .coast_cmd(coast_cmd), .dir_rev(dir_rev), .speed_ref(speed_ref),
      .mode_led(mode_led), .run_led(run_led), .prog_led(prog_led), .fwd_led(fwd_led),
      .rev_led(rev_led), .remote_led(remote_led), .test_banner_a(banner),
      .disp_value(disp_value), .disp_func(disp_func), .disp_show_value(show),
      .disp_mode(disp_mode));
   dkp_panel_model u_panel (.pclk(pclk), .go(go), .key_idx(key_idx), .key_raw(key_raw),
      .busy(busy));
   initial begin
      forever #20 pclk = ~pclk;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test;
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      rd = prdata;
      psel <= 0;
      penable <= 0;
      if (i >= 50) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   task automatic press(input logic [2:0] k);
      int i;
      @(posedge pclk);
      key_idx <= k;
      go <= 1;
      @(posedge pclk);
      go <= 0;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while ((busy === 1'b1 || i < 2) && i < 60);
      repeat (8) @(posedge pclk);
      if (i >= 60) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      #1 check("banner on", banner, 1);
      apb(0, `DKP_CTRL_OFF, 0);
      check("ctrl reset", rd, `DKP_CTRL_RESET);
      repeat (30) @(posedge pclk);
      check("banner off", banner, 0);
      check("restored mode", disp_mode, 2'h1);
      for (int r = 0; r < 6; r++) begin
         press(rows[r][6:4]);
         check("run", run_cmd, rows[r][3]);
         check("reverse led", rev_led, rows[r][2]);
         check("mode", disp_mode, rows[r][1:0]);
         check("mode led", mode_led, 3'h1 << rows[r][1:0]);
      end
      apb(1, `DKP_CTRL_OFF, 32'h0000_0004);
      press(0);
      press(2);
      press(2);
      check("ref mode", disp_mode, `DKP_DM_REF);
      check("ref leds", mode_led, 3'h7);
      check("ref value", disp_value, 8'h37);
      trip <= 1;
      fault_code <= 8'h21;
      fault_present <= 1;
      @(posedge pclk);
      trip <= 0;
      repeat (4) @(posedge pclk);
      check("trip run", run_cmd, 0);
      check("trip coast", coast_cmd, 1);
      press(0);
      check("start in fault", run_cmd, 0);
      apb(0, `DKP_ELOG_OFF, 0);
      check("log entry", rd[7:0], 8'h21);
      press(1);
      apb(0, `DKP_STAT_OFF, 0);
      check("fault kept", rd[9], 1);
      fault_present <= 0;
      press(1);
      apb(0, `DKP_STAT_OFF, 0);
      check("fault cleared", rd[9], 0);
      apb(1, `DKP_CTRL_OFF, 32'h0000_0005);
      press(0);
      press(3);
      check("remote start", run_cmd, 0);
      check("remote dir", rev_led, 1);
      check("remote led", remote_led, 1);
      apb(1, `DKP_CTRL_OFF, 32'h0000_0004);
      press(2);
      check("prog led on", prog_led, 1);
      check("first func", disp_func, 5'h00);
      press(5);
      check("wrap to log", disp_func, `DKP_FUNC_ERR);
      press(5);
      check("last func", disp_func, `DKP_FUNC_LAST);
      press(2);
      check("show value", show, 1);
      press(2);
      check("show number", show, 0);
      press(1);
      check("prog led off", prog_led, 0);
      apb(0, 12'h020, 32'hFFFF_FFFF);
      check("unmapped read", rd, 0);
      press(4);
      press(4);
      press(5);
      check("speed step", speed_ref, 8'h01);
      check("forward led", fwd_led, 0);
      press(0);
      press(1);
      check("ramp stop", coast_cmd, 0);
      apb(1, `DKP_CTRL_OFF, 32'h0000_0006);
      press(0);
      press(1);
      check("coast stop", coast_cmd, 1);
      trip <= 1;
      fault_code <= 8'h22;
      @(posedge pclk);
      fault_code <= 8'h23;
      @(posedge pclk);
      fault_code <= 8'h24;
      @(posedge pclk);
      trip <= 0;
      apb(0, `DKP_ELOG_OFF, 0);
      check("log full", rd, 32'h0023_2221);
      press(2);
      press(5);
      press(4);
      check("log step", disp_value, 8'h22);
      press(1);
      apb(0, `DKP_STAT_OFF, 0);
      check("log cleared", rd[11:9], 3'h0);
      clk_en <= 0;
      press(4);
      clk_en <= 1;
      repeat (4) @(posedge pclk);
      check("frozen", disp_value, 8'h21);
      presetn <= 0;
      @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      #1 check("reset banner", banner, 1);
      check("reset prog", prog_led, 0);
      repeat (30) @(posedge pclk);
      check("reset mode", disp_mode, 2'h1);
      finish_test();
   end
endmodule // drive_keypad_ui_controller_test
`default_nettype wire
